/* File: mcb_pkg.sv */
// constants and types shared by the machine csr bank files
package mcb_pkg;

   // ==========================================================================
   // csr addresses
   localparam logic [11:0] ADDR_USER_STATUS_ALIAS = 12'h000;
   localparam logic [11:0] ADDR_SUPERVISOR_STATUS_ALIAS = 12'h100;
   localparam logic [11:0] ADDR_MACHINE_STATUS = 12'h300;
   localparam logic [11:0] ADDR_ISA_DESCRIPTION = 12'h301;
   localparam logic [11:0] ADDR_INTERRUPT_ENABLE = 12'h304;
   localparam logic [11:0] ADDR_INTERRUPT_PENDING = 12'h344;
   localparam logic [11:0] ADDR_VENDOR_IDENTITY = 12'hf11;
   localparam logic [11:0] ADDR_ARCHITECTURE_IDENTITY = 12'hf12;
   localparam logic [11:0] ADDR_IMPLEMENTATION_IDENTITY = 12'hf13;
   localparam logic [11:0] ADDR_HART_IDENTITY = 12'hf14;

   // ==========================================================================
   // machine status fields
   localparam int STATUS_GLOBAL_IRQ_ENABLE_BIT = 3;
   localparam int STATUS_PRIOR_IRQ_ENABLE_BIT = 7;
   localparam int STATUS_PRIOR_PRIVILEGE_LSB = 11;
   localparam logic [1:0] PRIOR_PRIVILEGE_MACHINE = 2'h3;
   localparam int STATUS_DIRTY_SUMMARY_BIT = 31;
   localparam logic RESET_GLOBAL_IRQ_ENABLE = 1'h0;
   localparam logic RESET_PRIOR_IRQ_ENABLE = 1'h0;

   // ==========================================================================
   // isa description fields
   localparam logic [1:0] ISA_BASE_RV32 = 2'h1;
   localparam int ISA_BASE_LSB = 30;
   localparam int ISA_EXT_COMPRESSED_BIT = 2;
   localparam int ISA_EXT_BASE_INTEGER_BIT = 8;
   localparam int ISA_EXT_MULDIV_BIT = 12;
   localparam int ISA_EXT_CSR_FENCE_BIT = 25;

   // ==========================================================================
   // interrupt enable / pending fields (same positions in both)
   localparam int IRQ_SOFT_BIT = 3;
   localparam int IRQ_TIMER_BIT = 7;
   localparam int IRQ_EXT_BIT = 11;
   localparam int IRQ_ECC_UNCORR_BIT = 16;
   localparam int IRQ_ECC_CORR_BIT = 17;
   localparam int IRQ_SYS_LSB = 24;
   localparam int IRQ_SYS_COUNT = 6;
   localparam int IRQ_AUX_BIT = 30;
   localparam logic [31:0] IRQ_ENABLE_WRITE_MASK = 32'h7f03_0888;
   localparam logic [31:0] IRQ_PENDING_WRITE_MASK = 32'h7f00_0000;
   localparam logic [31:0] RESET_IRQ_ENABLE = 32'h0000_0000;
   localparam logic [31:0] RESET_IRQ_PENDING = 32'h0000_0000;

   // ==========================================================================
   // identity values, arbitrary neutral defaults
   localparam logic [31:0] VENDOR_CODE_DEFAULT = 32'h0000_0000;
   localparam logic [31:0] ARCH_CODE_DEFAULT = 32'h0000_0000;
   localparam logic [31:0] IMPL_CODE_DEFAULT = 32'h0000_0001;
   localparam logic [31:0] HART_NUMBER_DEFAULT = 32'h0000_0000;

   // ==========================================================================
   // access operations and interrupt codes
   typedef enum logic [1:0] {
      OP_READ = 2'b00,
      OP_WRITE = 2'b01,
      OP_SET = 2'b10,
      OP_CLEAR = 2'b11
   } mcb_op_type;

   localparam int IRQ_LINES = 12;
   localparam logic [4:0] IRQ_CODE_NONE = 5'h00;

endpackage

/* File: mcb_sync.sv */
// two-flop synchroniser for asynchronous interrupt lines
`timescale 1ns/1ps
`default_nettype none

module mcb_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   // ==========================================================================
   // first stage feeds the second stage only
   logic [WIDTH-1:0] stageOne;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stageOne <= '0;
         syncOut <= '0;
      end else begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end

endmodule // mcb_sync
`default_nettype wire

/* File: mcb_irq_prio.sv */
// fixed-priority selection of the interrupt to present to the hart
`timescale 1ns/1ps
`default_nettype none

module mcb_irq_prio (
   input wire logic [31:0] activeIrqs,
   output logic anyActive,
   output logic [4:0] irqCode
);

   // ==========================================================================
   // lowest bit position wins: soft, timer, external, ecc, system, aux
   always_comb begin
      anyActive = 1'b0;
      irqCode = mcb_pkg::IRQ_CODE_NONE;
      for (int i = 31; i >= 0; i--) begin
         if (activeIrqs[i]) begin
            anyActive = 1'b1;
            irqCode = 5'(i);
         end
      end
   end

endmodule // mcb_irq_prio
`default_nettype wire

/* File: mcb_machine_csr_bank.sv */
// machine-mode control and status register bank of a machine-only hart
//
// Functional notes
// - unimplemented csrs addressable, read fixed zero
// - vendor identity read-only build constant
// - architecture and implementation identity read-only constants
// - hart identity read-only build constant
// - status: only two irq enables stored
// - prior privilege always reads machine mode
// - other status bits zero, writes ignored
// - extension state absent; dirty summary reads zero
// - status aliases legal, read zero, ignore writes
// - global irq enable clears on reset
// - isa register hardwired, base field rv32
// - base integer and csr/fence bits set
// - compressed and muldiv follow build, others zero
// - enable register holds documented read-write enables
// - pending: core flags read-only, system bits writable
// - ecc interrupt bits only when ecc configured
`timescale 1ns/1ps
`default_nettype none

module mcb_machine_csr_bank #(
   parameter logic [31:0] VENDOR_CODE = mcb_pkg::VENDOR_CODE_DEFAULT,
   parameter logic [31:0] ARCH_CODE = mcb_pkg::ARCH_CODE_DEFAULT,
   parameter logic [31:0] IMPL_CODE = mcb_pkg::IMPL_CODE_DEFAULT,
   parameter logic [31:0] HART_NUMBER = mcb_pkg::HART_NUMBER_DEFAULT,
   parameter bit HAS_COMPRESSED = 1'b1,
   parameter bit HAS_MULDIV = 1'b1,
   parameter bit HAS_ECC = 1'b0,
   parameter bit HAS_SYS_IRQ = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic csrReq,
   input wire logic [11:0] csrAddr,
   input wire logic [1:0] csrOp,
   input wire logic [31:0] csrWdata,
   output logic [31:0] csrRdata,
   output logic csrAck,
   input wire logic trapEnter,
   input wire logic trapReturn,
   input wire logic softIrqIn,
   input wire logic timerIrqIn,
   input wire logic extIrqIn,
   input wire logic eccUncorrIn,
   input wire logic eccCorrIn,
   input wire logic [5:0] sysIrqIn,
   input wire logic auxIrqIn,
   output logic globalIrqEnable,
   output logic irqRequest,
   output logic [4:0] irqCode
);

   // ==========================================================================
   // helpers
   function automatic logic [31:0] mergeWrite(
      input logic [31:0] oldValue,
      input logic [1:0] op,
      input logic [31:0] data,
      input logic [31:0] writeMask
   );
      logic [31:0] result;
      // set and clear take the data as a bit mask
      result = oldValue;
      case (op)
         mcb_pkg::OP_WRITE: result = data;
         mcb_pkg::OP_SET: result = oldValue | data;
         mcb_pkg::OP_CLEAR: result = oldValue & ~data;
         default: result = oldValue;
      endcase
      // only writable positions take the new value
      mergeWrite = (result & writeMask) | (oldValue & ~writeMask);
   endfunction

   function automatic logic isWrite(input logic [1:0] op);
      isWrite = (op != mcb_pkg::OP_READ);
   endfunction

   // ==========================================================================
   // build-time masks
   // unconfigured positions neither store nor read back
   localparam logic [31:0] ECC_MASK = HAS_ECC ?
      ((32'h1 << mcb_pkg::IRQ_ECC_UNCORR_BIT) | (32'h1 << mcb_pkg::IRQ_ECC_CORR_BIT)) :
      32'h0000_0000;
   localparam logic [31:0] SYS_MASK = HAS_SYS_IRQ ?
      (32'h3f << mcb_pkg::IRQ_SYS_LSB) : 32'h0000_0000;
   localparam logic [31:0] ENABLE_MASK = mcb_pkg::IRQ_ENABLE_WRITE_MASK &
      ~(((32'h1 << mcb_pkg::IRQ_ECC_UNCORR_BIT) | (32'h1 << mcb_pkg::IRQ_ECC_CORR_BIT)) &
        ~ECC_MASK) & ~((32'h3f << mcb_pkg::IRQ_SYS_LSB) & ~SYS_MASK);
   localparam logic [31:0] PENDING_MASK = mcb_pkg::IRQ_PENDING_WRITE_MASK &
      ~((32'h3f << mcb_pkg::IRQ_SYS_LSB) & ~SYS_MASK);

   // ==========================================================================
   // synchronised interrupt lines; they arrive from outside this clock
   logic [mcb_pkg::IRQ_LINES-1:0] rawIrqs;
   logic [mcb_pkg::IRQ_LINES-1:0] syncIrqs;
   logic softSync;
   logic timerSync;
   logic extSync;
   logic eccUncorrSync;
   logic eccCorrSync;
   logic [5:0] sysSync;
   logic auxSync;

   // ==========================================================================
   // packing, one source per position; the slices below undo it
   assign rawIrqs[0] = softIrqIn;
   assign rawIrqs[1] = timerIrqIn;
   assign rawIrqs[2] = extIrqIn;
   assign rawIrqs[3] = eccUncorrIn;
   assign rawIrqs[4] = eccCorrIn;
   assign rawIrqs[10:5] = sysIrqIn;
   assign rawIrqs[11] = auxIrqIn;

   // ==========================================================================
   // two-flop synchroniser
   // a level shorter than one clock can be lost
   mcb_sync #(
      .WIDTH(mcb_pkg::IRQ_LINES)
   ) irqSync (
      .clk(clk),
      .resetn(resetn),
      .asyncIn(rawIrqs),
      .syncOut(syncIrqs)
   );

   // ==========================================================================
   // synchronised lines by name
   assign softSync = syncIrqs[0];
   assign timerSync = syncIrqs[1];
   assign extSync = syncIrqs[2];
   assign eccUncorrSync = syncIrqs[3];
   assign eccCorrSync = syncIrqs[4];
   assign sysSync = syncIrqs[10:5];
   assign auxSync = syncIrqs[11];

   // ==========================================================================
   // address decode
   // hit flags serve both the write strobes and the read mux
   // unlisted addresses hit nothing and read zero
   logic hitStatus;
   logic hitEnable;
   logic hitPending;
   logic doWrite;

   always_comb begin
      hitStatus = 1'b0;
      hitEnable = 1'b0;
      hitPending = 1'b0;
      if (csrAddr == mcb_pkg::ADDR_MACHINE_STATUS) begin
         hitStatus = 1'b1;
      end else if (csrAddr == mcb_pkg::ADDR_INTERRUPT_ENABLE) begin
         hitEnable = 1'b1;
      end else if (csrAddr == mcb_pkg::ADDR_INTERRUPT_PENDING) begin
         hitPending = 1'b1;
      end
   end

   assign doWrite = csrReq && isWrite(csrOp);

   // ==========================================================================
   // machine status storage
   logic globalIe;
   logic priorIe;
   logic [31:0] statusValue;
   logic [31:0] next_status;

   always_comb begin
      statusValue = 32'h0000_0000;
      statusValue[mcb_pkg::STATUS_GLOBAL_IRQ_ENABLE_BIT] = globalIe;
      statusValue[mcb_pkg::STATUS_PRIOR_IRQ_ENABLE_BIT] = priorIe;
      statusValue[mcb_pkg::STATUS_PRIOR_PRIVILEGE_LSB +: 2] =
         mcb_pkg::PRIOR_PRIVILEGE_MACHINE;
      // no extension state exists, so the summary bit stays zero
      statusValue[mcb_pkg::STATUS_DIRTY_SUMMARY_BIT] = 1'b0;
   end

   assign next_status = mergeWrite(statusValue, csrOp, csrWdata,
      (32'h1 << mcb_pkg::STATUS_GLOBAL_IRQ_ENABLE_BIT) |
      (32'h1 << mcb_pkg::STATUS_PRIOR_IRQ_ENABLE_BIT));

   // trap entry and return take priority over a software write in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         globalIe <= mcb_pkg::RESET_GLOBAL_IRQ_ENABLE;
         // no defined reset value; zero keeps runs repeatable
         priorIe <= mcb_pkg::RESET_PRIOR_IRQ_ENABLE;
      end else if (trapEnter) begin
         priorIe <= globalIe;
         globalIe <= 1'b0;
      end else if (trapReturn) begin
         globalIe <= priorIe;
         priorIe <= 1'b1;
      end else if (doWrite && hitStatus) begin
         globalIe <= next_status[mcb_pkg::STATUS_GLOBAL_IRQ_ENABLE_BIT];
         priorIe <= next_status[mcb_pkg::STATUS_PRIOR_IRQ_ENABLE_BIT];
      end
   end

   assign globalIrqEnable = globalIe;

   // ==========================================================================
   // interrupt enable storage
   // only masked positions ever store
   logic [31:0] enableReg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         enableReg <= mcb_pkg::RESET_IRQ_ENABLE;
      end else if (doWrite && hitEnable) begin
         enableReg <= mergeWrite(enableReg, csrOp, csrWdata, ENABLE_MASK);
      end
   end

   // ==========================================================================
   // interrupt pending: writable system and aux flags
   // a line still high re-sets its flag, so a clear never hides a live event
   logic [31:0] writablePending;
   logic [31:0] pendingSets;
   logic [31:0] pendingAfterWrite;

   always_comb begin
      pendingSets = 32'h0000_0000;
      pendingSets[mcb_pkg::IRQ_SYS_LSB +: 6] = sysSync;
      pendingSets[mcb_pkg::IRQ_AUX_BIT] = auxSync;
      pendingSets = pendingSets & PENDING_MASK;
   end

   assign pendingAfterWrite = (doWrite && hitPending) ?
      mergeWrite(writablePending, csrOp, csrWdata, PENDING_MASK) : writablePending;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         writablePending <= mcb_pkg::RESET_IRQ_PENDING;
      end else begin
         writablePending <= pendingAfterWrite | pendingSets;
      end
   end

   // read-only flags mirror the synchronised lines
   logic [31:0] pendingValue;

   always_comb begin
      pendingValue = writablePending & PENDING_MASK;
      pendingValue[mcb_pkg::IRQ_SOFT_BIT] = softSync;
      pendingValue[mcb_pkg::IRQ_TIMER_BIT] = timerSync;
      pendingValue[mcb_pkg::IRQ_EXT_BIT] = extSync;
      pendingValue[mcb_pkg::IRQ_ECC_UNCORR_BIT] =
         eccUncorrSync & ECC_MASK[mcb_pkg::IRQ_ECC_UNCORR_BIT];
      pendingValue[mcb_pkg::IRQ_ECC_CORR_BIT] =
         eccCorrSync & ECC_MASK[mcb_pkg::IRQ_ECC_CORR_BIT];
   end

   // ==========================================================================
   // isa description, fixed at build time
   // no storage, so writes have nothing to change
   logic [31:0] isaValue;

   always_comb begin
      isaValue = 32'h0000_0000;
      isaValue[mcb_pkg::ISA_BASE_LSB +: 2] = mcb_pkg::ISA_BASE_RV32;
      isaValue[mcb_pkg::ISA_EXT_BASE_INTEGER_BIT] = 1'b1;
      isaValue[mcb_pkg::ISA_EXT_CSR_FENCE_BIT] = 1'b1;
      isaValue[mcb_pkg::ISA_EXT_COMPRESSED_BIT] = HAS_COMPRESSED;
      isaValue[mcb_pkg::ISA_EXT_MULDIV_BIT] = HAS_MULDIV;
   end

   // ==========================================================================
   // read multiplexer; every other address is legal and reads zero
   logic [31:0] readValue;

   always_comb begin
      readValue = 32'h0000_0000;
      if (hitStatus) begin
         readValue = statusValue;
      end else if (hitEnable) begin
         readValue = enableReg & ENABLE_MASK;
      end else if (hitPending) begin
         readValue = pendingValue;
      end else if (csrAddr == mcb_pkg::ADDR_ISA_DESCRIPTION) begin
         readValue = isaValue;
      end else if (csrAddr == mcb_pkg::ADDR_VENDOR_IDENTITY) begin
         readValue = VENDOR_CODE;
      end else if (csrAddr == mcb_pkg::ADDR_ARCHITECTURE_IDENTITY) begin
         readValue = ARCH_CODE;
      end else if (csrAddr == mcb_pkg::ADDR_IMPLEMENTATION_IDENTITY) begin
         readValue = IMPL_CODE;
      end else if (csrAddr == mcb_pkg::ADDR_HART_IDENTITY) begin
         readValue = HART_NUMBER;
      end else if (csrAddr == mcb_pkg::ADDR_SUPERVISOR_STATUS_ALIAS ||
                   csrAddr == mcb_pkg::ADDR_USER_STATUS_ALIAS) begin
         // aliases carry no machine bits and never trap
         readValue = 32'h0000_0000;
      end
   end

   // answer one cycle after the request with the value before the write
   // read data holds between answers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         csrRdata <= 32'h0000_0000;
         csrAck <= 1'b0;
      end else begin
         csrAck <= csrReq;
         if (csrReq) begin
            csrRdata <= readValue;
         end
      end
   end

   // ==========================================================================
   // interrupt presentation
   // the code is the bit position, which is also the cause code
   // registered so the request is steady for whole cycles
   logic [31:0] activeIrqs;
   logic anyActive;
   logic [4:0] selectedCode;

   assign activeIrqs = pendingValue & enableReg & ENABLE_MASK;

   mcb_irq_prio prio (
      .activeIrqs(activeIrqs),
      .anyActive(anyActive),
      .irqCode(selectedCode)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqRequest <= 1'b0;
         irqCode <= mcb_pkg::IRQ_CODE_NONE;
      end else begin
         irqRequest <= anyActive && globalIe;
         irqCode <= anyActive ? selectedCode : mcb_pkg::IRQ_CODE_NONE;
      end
   end

endmodule // mcb_machine_csr_bank
`default_nettype wire

/* File: mcb_csr_bank_sva.sv */
// assertion checker for the machine csr bank ports
`timescale 1ns/1ps
`default_nettype none
module mcb_csr_bank_sva #(
   parameter logic [31:0] VENDOR_CODE = 32'h0000_0000,
   parameter logic [31:0] ARCH_CODE = 32'h0000_0000,
   parameter logic [31:0] IMPL_CODE = 32'h0000_0000,
   parameter logic [31:0] HART_NUMBER = 32'h0000_0000,
   parameter bit HAS_COMPRESSED = 1'b1,
   parameter bit HAS_MULDIV = 1'b1,
   parameter bit HAS_ECC = 1'b0,
   parameter bit HAS_SYS_IRQ = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic csrReq,
   input wire logic [11:0] csrAddr,
   input wire logic [1:0] csrOp,
   input wire logic [31:0] csrWdata,
   input wire logic [31:0] csrRdata,
   input wire logic csrAck,
   input wire logic trapEnter,
   input wire logic globalIrqEnable,
   input wire logic irqRequest,
   input wire logic [4:0] irqCode
);
   // ==========================================================================
   // expected fixed values
   localparam logic [31:0] ISA_VALUE = 32'h4200_0100 | (HAS_COMPRESSED ? 32'h4 : 32'h0)
      | (HAS_MULDIV ? 32'h1000 : 32'h0);
   localparam logic [31:0] IRQ_MASK = 32'h4000_0888 | (HAS_ECC ? 32'h3_0000 : 32'h0)
      | (HAS_SYS_IRQ ? 32'h3f00_0000 : 32'h0);
   logic rdReq;
   assign rdReq = csrReq && csrOp == 2'h0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ==========================================================================
   // properties
   property p_ack; 1'b1 |=> csrAck == $past(csrReq); endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after request");
   property p_vendor; rdReq && csrAddr == 12'hf11 |=> csrRdata == VENDOR_CODE; endproperty
   a_vendor: assert property (p_vendor) else $error("vendor identity wrong");
   property p_arch_impl;
      rdReq && csrAddr inside {12'hf12, 12'hf13}
         |=> csrRdata == ($past(csrAddr[0]) ? IMPL_CODE : ARCH_CODE);
   endproperty
   a_arch_impl: assert property (p_arch_impl) else $error("arch or impl identity wrong");
   property p_hart; rdReq && csrAddr == 12'hf14 |=> csrRdata == HART_NUMBER; endproperty
   a_hart: assert property (p_hart) else $error("hart identity wrong");
   property p_status_fixed;
      rdReq && csrAddr == 12'h300 |=> (csrRdata & ~32'h0000_0088) == 32'h0000_1800;
   endproperty
   a_status_fixed: assert property (p_status_fixed) else $error("status fixed bits wrong");
   property p_status_gie;
      rdReq && csrAddr == 12'h300 |=> csrRdata[3] == $past(globalIrqEnable);
   endproperty
   a_status_gie: assert property (p_status_gie) else $error("status bit 3 not global enable");
   property p_alias; rdReq && csrAddr inside {12'h000, 12'h100} |=> csrRdata == 32'h0; endproperty
   a_alias: assert property (p_alias) else $error("status alias not zero");
   property p_isa; rdReq && csrAddr == 12'h301 |=> csrRdata == ISA_VALUE; endproperty
   a_isa: assert property (p_isa) else $error("isa description wrong");
   property p_enable_wr;
      (csrReq && csrOp == 2'h1 && csrAddr == 12'h304) ##1 !csrReq
         ##1 (rdReq && csrAddr == 12'h304) |=> csrRdata == ($past(csrWdata, 3) & IRQ_MASK);
   endproperty
   a_enable_wr: assert property (p_enable_wr) else $error("enable readback wrong");
   property p_pending_bits;
      rdReq && csrAddr == 12'h344 |=> (csrRdata & ~IRQ_MASK) == 32'h0;
   endproperty
   a_pending_bits: assert property (p_pending_bits) else $error("pending stray bits");
   property p_reset_gie;
      disable iff (1'b0) !resetn |-> !globalIrqEnable && !irqRequest;
   endproperty
   a_reset_gie: assert property (p_reset_gie) else $error("global enable set in reset");
   property p_trap; trapEnter |=> !globalIrqEnable; endproperty
   a_trap: assert property (p_trap) else $error("trap entry left global enable");
   property p_irq_gate; irqRequest |-> $past(globalIrqEnable) && irqCode != 5'h00; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request without global enable");
   c_irq: cover property (irqRequest);
   c_trap: cover property (trapEnter ##1 !globalIrqEnable);
   c_enable: cover property (rdReq && csrAddr == 12'h304);
endmodule // mcb_csr_bank_sva
bind mcb_machine_csr_bank mcb_csr_bank_sva #(.VENDOR_CODE(VENDOR_CODE), .ARCH_CODE(ARCH_CODE),
   .IMPL_CODE(IMPL_CODE), .HART_NUMBER(HART_NUMBER), .HAS_COMPRESSED(HAS_COMPRESSED),
   .HAS_MULDIV(HAS_MULDIV), .HAS_ECC(HAS_ECC), .HAS_SYS_IRQ(HAS_SYS_IRQ)) mcb_csr_bank_sva_inst (
   .clk(clk), .resetn(resetn), .csrReq(csrReq), .csrAddr(csrAddr), .csrOp(csrOp),
   .csrWdata(csrWdata), .csrRdata(csrRdata), .csrAck(csrAck), .trapEnter(trapEnter),
   .globalIrqEnable(globalIrqEnable), .irqRequest(irqRequest), .irqCode(irqCode));
`default_nettype wire

/* File: mcb_pipe_model.sv */
// pipeline-side model issuing csr access instructions
`timescale 1ns/1ps
`default_nettype none
module mcb_pipe_model (
   input wire logic clk,
   input wire logic [31:0] csrRdata,
   input wire logic csrAck,
   output var logic csrReq,
   output var logic [11:0] csrAddr,
   output var logic [1:0] csrOp,
   output var logic [31:0] csrWdata
);
   initial begin
      csrReq = 1'b0;
      csrAddr = 12'h000;
      csrOp = 2'h0;
      csrWdata = 32'h0;
   end
   // idle fields show the inverse so a stale value is never mistaken for a live one
   task automatic access(input logic [11:0] addr, input logic [1:0] op,
         input logic [31:0] data, output logic [31:0] rdata, output logic ack);
      @(posedge clk);
      #1;
      csrReq = 1'b1;
      csrAddr = addr;
      csrOp = op;
      csrWdata = data;
      @(posedge clk);
      #1;
      csrReq = 1'b0;
      csrAddr = ~addr;
      csrOp = ~op;
      csrWdata = ~data;
      ack = csrAck;
      rdata = csrRdata;
   endtask
endmodule // mcb_pipe_model
`default_nettype wire

/* File: tb.sv */
// self-checking testbench for the machine csr bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk, resetn, csrReq, csrAck, globalIrqEnable, irqRequest;
   logic trapEnter, trapReturn, softIrqIn, timerIrqIn, extIrqIn, eccUncorrIn, eccCorrIn, auxIrqIn;
   logic [11:0] csrAddr;
   logic [1:0] csrOp;
   logic [31:0] csrWdata, csrRdata, rd;
   logic [5:0] sysIrqIn;
   logic [4:0] irqCode;
   logic ak;
   int nMismatch = 0;
   int totalChecks = 0;
   mcb_machine_csr_bank mcb_machine_csr_bank_inst (.clk(clk), .resetn(resetn), .csrReq(csrReq),
      .csrAddr(csrAddr), .csrOp(csrOp), .csrWdata(csrWdata), .csrRdata(csrRdata), .csrAck(csrAck),
      .trapEnter(trapEnter), .trapReturn(trapReturn), .softIrqIn(softIrqIn),
      .timerIrqIn(timerIrqIn), .extIrqIn(extIrqIn), .eccUncorrIn(eccUncorrIn),
      .eccCorrIn(eccCorrIn), .sysIrqIn(sysIrqIn), .auxIrqIn(auxIrqIn),
      .globalIrqEnable(globalIrqEnable), .irqRequest(irqRequest), .irqCode(irqCode));
   mcb_pipe_model mcb_pipe_model_inst (.clk(clk), .csrRdata(csrRdata), .csrAck(csrAck),
      .csrReq(csrReq), .csrAddr(csrAddr), .csrOp(csrOp), .csrWdata(csrWdata));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ==========================================================================
   // shared helpers
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         nMismatch++;
      end
   endtask
   task automatic xfer(input logic [11:0] addr, input logic [1:0] op, input logic [31:0] data);
      mcb_pipe_model_inst.access(addr, op, data, rd, ak);
      chk("csrAck", 32'h1, {31'h0, ak});
   endtask
   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
      xfer(addr, 2'h0, 32'h0);
      chk($sformatf("read %h", addr), exp, rd);
   endtask
   task automatic pulse(ref logic sig);
      @(posedge clk);
      #1;
      sig = 1'b1;
      @(posedge clk);
      #1;
      sig = 1'b0;
   endtask
   // ==========================================================================
   // scenarios
   task automatic test_reset();
      chk("globalIrqEnable", 32'h0, {31'h0, globalIrqEnable});
      chk("irqRequest", 32'h0, {31'h0, irqRequest});
      rdchk(12'h300, 32'h0000_1800);
      $display("test_reset done");
   endtask
   task automatic test_fixed();
      logic [11:0] a [7] = '{12'hf11, 12'hf12, 12'hf13, 12'hf14, 12'h000, 12'h100, 12'h7c0};
      logic [31:0] e [7] = '{mcb_pkg::VENDOR_CODE_DEFAULT, mcb_pkg::ARCH_CODE_DEFAULT,
         mcb_pkg::IMPL_CODE_DEFAULT, mcb_pkg::HART_NUMBER_DEFAULT, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 7; i++) begin
         xfer(a[i], 2'h1, 32'hffff_ffff);
         rdchk(a[i], e[i]);
      end
      xfer(12'h301, 2'h1, 32'h0);
      rdchk(12'h301, 32'h4200_1104);
      $display("test_fixed done");
   endtask
   task automatic test_status();
      xfer(12'h300, 2'h1, 32'hffff_ffff);
      rdchk(12'h300, 32'h0000_1888);
      xfer(12'h300, 2'h3, 32'h0000_0008);
      rdchk(12'h300, 32'h0000_1880);
      xfer(12'h300, 2'h2, 32'h0000_0008);
      chk("globalIrqEnable", 32'h1, {31'h0, globalIrqEnable});
      $display("test_status done");
   endtask
   task automatic test_irq_regs();
      xfer(12'h304, 2'h1, 32'hffff_ffff);
      rdchk(12'h304, 32'h7f00_0888);
      xfer(12'h344, 2'h1, 32'hffff_ffff);
      rdchk(12'h344, 32'h7f00_0000);
      xfer(12'h344, 2'h3, 32'hffff_ffff);
      rdchk(12'h344, 32'h0);
      xfer(12'h304, 2'h1, 32'h0000_0800);
      $display("test_irq_regs done");
   endtask
   task automatic test_irq();
      {softIrqIn, timerIrqIn, extIrqIn, eccUncorrIn, eccCorrIn} = 5'h1f;
      sysIrqIn = 6'h01;
      auxIrqIn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("irqRequest", 32'h1, {31'h0, irqRequest});
      chk("irqCode", 32'd11, {27'h0, irqCode});
      rdchk(12'h344, 32'h4100_0888);
      // a clear while the lines are still high is overridden by the set
      xfer(12'h344, 2'h3, 32'h4100_0000);
      rdchk(12'h344, 32'h4100_0888);
      xfer(12'h304, 2'h2, 32'h0000_0088);
      @(posedge clk);
      #1;
      chk("irqCode", 32'd3, {27'h0, irqCode});
      {eccUncorrIn, eccCorrIn, auxIrqIn} = 3'h0;
      sysIrqIn = 6'h00;
      // lines stay high, so only the global enable can drop the request
      xfer(12'h300, 2'h3, 32'h0000_0008);
      repeat (3) @(posedge clk);
      #1;
      chk("irqRequest", 32'h0, {31'h0, irqRequest});
      {softIrqIn, timerIrqIn, extIrqIn} = 3'h0;
      xfer(12'h344, 2'h3, 32'h4100_0000);
      rdchk(12'h344, 32'h0);
      $display("test_irq done");
   endtask
   task automatic test_trap();
      xfer(12'h300, 2'h1, 32'h0000_0008);
      pulse(trapEnter);
      chk("globalIrqEnable", 32'h0, {31'h0, globalIrqEnable});
      rdchk(12'h300, 32'h0000_1880);
      pulse(trapReturn);
      chk("globalIrqEnable", 32'h1, {31'h0, globalIrqEnable});
      $display("test_trap done");
   endtask
   task automatic endOfTest();
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      nMismatch++;
      endOfTest();
   end
   initial begin
      resetn = 1'b0;
      {trapEnter, trapReturn, softIrqIn, timerIrqIn, extIrqIn, eccUncorrIn, eccCorrIn} = 7'h0;
      auxIrqIn = 1'b0;
      sysIrqIn = 6'h00;
      repeat (3) @(posedge clk);
      #1;
      resetn = 1'b1;
      test_reset();
      test_fixed();
      test_status();
      test_irq_regs();
      test_irq();
      test_trap();
      endOfTest();
   end
endmodule // tb
`default_nettype wire
